// ==== src/ssrp_consts.vh ====
// Constants for the serial configuration port
`ifndef SSRP_CONSTS_VH
`define SSRP_CONSTS_VH
`define SSRP_ADDR_W 9
`define SSRP_DATA_W 16
`define SSRP_ADDR_LAST 8
`define SSRP_TYPE_BIT 9
`define SSRP_READ_START 10
`define SSRP_WRITE_LAST 25
`define SSRP_CNT_W 5
`define SSRP_CNT_ONE 5'h01
`define SSRP_CNT_MAX 5'h1F
`endif

// ==== src/ssrp_sync.v ====
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module ssrp_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire clk,
	input wire resetn,
	input wire d,
	output reg q
);
	reg meta;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== src/ssrp_port.v ====
// Serial configuration port of the sensor, sampled on the system clock
//
// Overview of operation
// - The port has four pins: serial clock, active-low select, data in and data out.
// - Bits move only on serial clock edges, and those pins are asynchronous to clk.
// - Each access carries a 9-bit address and a 16-bit data word.
// - The data-in line is sampled on rising serial clock edges and changes on falling ones.
// - The tenth bit is the type: high for a write, low for a read.
// - A write carries 16 data bits MSB first after the type bit and is stored at the address.
// - A read returns the addressed 16-bit register on the data-out line MSB first.
// - The data-out line is released whenever no read data is being returned.
`timescale 1ns/1ps
`default_nettype none
`include "ssrp_consts.vh"
module ssrp_port #(
	parameter ADDR_W = `SSRP_ADDR_W,
	parameter DATA_W = `SSRP_DATA_W
) (
	input wire clk,
	input wire resetn,
	input wire sck,
	input wire ss_n,
	input wire mosi,
	output reg miso_out,
	output reg miso_oe,
	output reg [ADDR_W-1:0] wr_addr,
	output reg [DATA_W-1:0] wr_data,
	output reg wr_strobe,
	output reg [ADDR_W-1:0] rd_addr,
	output reg rd_strobe,
	input wire [DATA_W-1:0] rd_data
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_TYPE = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RWAIT = 3'h4;
	localparam ST_RDATA = 3'h5;
	localparam ST_DONE = 3'h6;

	wire sck_s;
	wire ss_n_s;
	wire mosi_s;
	wire sck_rise;
	wire sck_fall;
	reg sck_d;
	reg [2:0] state;
	reg [`SSRP_CNT_W-1:0] bit_cnt;
	reg [ADDR_W-1:0] addr_sh;
	reg [DATA_W-1:0] data_sh;
	reg [DATA_W-1:0] rd_sh;
	reg [2:0] next_state;
	reg [`SSRP_CNT_W-1:0] next_bit_cnt;
	reg [ADDR_W-1:0] next_addr_sh;
	reg [DATA_W-1:0] next_data_sh;
	reg [DATA_W-1:0] next_rd_sh;
	reg next_miso_out;
	reg next_miso_oe;
	reg [ADDR_W-1:0] next_wr_addr;
	reg [DATA_W-1:0] next_wr_data;
	reg next_wr_strobe;
	reg [ADDR_W-1:0] next_rd_addr;
	reg next_rd_strobe;

	// Shift one serial bit in at the low end of an address
	function [ADDR_W-1:0] shift_addr(input [ADDR_W-1:0] word, input bit_in);
		shift_addr = {word[ADDR_W-2:0], bit_in};
	endfunction

	// Shift one serial bit in at the low end of a data word
	function [DATA_W-1:0] shift_data(input [DATA_W-1:0] word, input bit_in);
		shift_data = {word[DATA_W-2:0], bit_in};
	endfunction

	// Count one serial clock edge, holding at the top
	function [`SSRP_CNT_W-1:0] count_up(input [`SSRP_CNT_W-1:0] cnt);
		if (cnt == `SSRP_CNT_MAX) begin
			count_up = cnt;
		end else begin
			count_up = cnt + `SSRP_CNT_ONE;
		end
	endfunction

	// Pins cross into clk domain
	ssrp_sync #(.RESET_VAL(1'b0)) u_sync_sck (.clk(clk), .resetn(resetn), .d(sck), .q(sck_s));
	ssrp_sync #(.RESET_VAL(1'b1)) u_sync_ss (.clk(clk), .resetn(resetn), .d(ss_n), .q(ss_n_s));
	ssrp_sync #(.RESET_VAL(1'b0)) u_sync_mosi (.clk(clk), .resetn(resetn), .d(mosi), .q(mosi_s));

	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;

	// Next-state decode of one access
	always @* begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_addr_sh = addr_sh;
		next_data_sh = data_sh;
		next_rd_sh = rd_sh;
		next_miso_out = miso_out;
		next_miso_oe = miso_oe;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strobe = 1'b0;
		next_rd_addr = rd_addr;
		next_rd_strobe = 1'b0;

		if (ss_n_s) begin
			// Deselect drops any partial access
			next_state = ST_IDLE;
			next_bit_cnt = {`SSRP_CNT_W{1'b0}};
			next_miso_oe = 1'b0;
			next_miso_out = 1'b0;
		end else begin
			if (sck_rise) begin
				next_bit_cnt = count_up(bit_cnt);
			end
			case (state)
				ST_IDLE: begin
					next_state = ST_ADDR;
					if (sck_rise) begin
						next_addr_sh = shift_addr(addr_sh, mosi_s);
					end
				end
				ST_ADDR: begin
					if (sck_rise) begin
						next_addr_sh = shift_addr(addr_sh, mosi_s);
						if (bit_cnt == `SSRP_ADDR_LAST) begin
							next_state = ST_TYPE;
						end
					end
				end
				ST_TYPE: begin
					if (sck_rise) begin
						if (mosi_s) begin
							next_state = ST_WDATA;
						end else begin
							next_state = ST_RWAIT;
							next_rd_addr = addr_sh;
							next_rd_strobe = 1'b1;
						end
					end
				end
				ST_WDATA: begin
					if (sck_rise) begin
						next_data_sh = shift_data(data_sh, mosi_s);
						if (bit_cnt == `SSRP_WRITE_LAST) begin
							next_state = ST_DONE;
							next_wr_addr = addr_sh;
							next_wr_data = shift_data(data_sh, mosi_s);
							next_wr_strobe = 1'b1;
						end
					end
				end
				ST_RWAIT: begin
					// Read word taken here, giving the register file a few clocks to answer
					if (sck_fall && bit_cnt == `SSRP_READ_START) begin
						next_state = ST_RDATA;
						next_miso_oe = 1'b1;
						next_miso_out = rd_data[DATA_W-1];
						next_rd_sh = shift_data(rd_data, 1'b0);
					end
				end
				ST_RDATA: begin
					if (sck_fall) begin
						if (bit_cnt > `SSRP_WRITE_LAST) begin
							next_state = ST_DONE;
							next_miso_oe = 1'b0;
							next_miso_out = 1'b0;
						end else begin
							next_miso_out = rd_sh[DATA_W-1];
							next_rd_sh = shift_data(rd_sh, 1'b0);
						end
					end
				end
				ST_DONE: begin
					// Extra serial clocks are ignored until deselect
					next_state = ST_DONE;
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	// State and output registers
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_d <= 1'b0;
			state <= ST_IDLE;
			bit_cnt <= {`SSRP_CNT_W{1'b0}};
			addr_sh <= {ADDR_W{1'b0}};
			data_sh <= {DATA_W{1'b0}};
			rd_sh <= {DATA_W{1'b0}};
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			wr_addr <= {ADDR_W{1'b0}};
			wr_data <= {DATA_W{1'b0}};
			wr_strobe <= 1'b0;
			rd_addr <= {ADDR_W{1'b0}};
			rd_strobe <= 1'b0;
		end else begin
			sck_d <= sck_s;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			addr_sh <= next_addr_sh;
			data_sh <= next_data_sh;
			rd_sh <= next_rd_sh;
			miso_out <= next_miso_out;
			miso_oe <= next_miso_oe;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strobe <= next_wr_strobe;
			rd_addr <= next_rd_addr;
			rd_strobe <= next_rd_strobe;
		end
	end
endmodule
`default_nettype wire

// ==== tb/ssrp_port_monitor.sv ====
// Checker on the port pins
`timescale 1ns/1ps
`default_nettype none
module ssrp_mon(
	input wire clk,
	input wire resetn,
	input wire ss_n,
	input wire wr_strobe,
	input wire rd_strobe,
	input wire miso_oe,
	input wire miso_out
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
a_wr_pulse: assert property (wr_strobe |=> !wr_strobe) else $error("wr");
a_rd_pulse: assert property (rd_strobe |=> !rd_strobe) else $error("rd");
a_strobe_sel: assert property (wr_strobe|rd_strobe |-> !ss_n) else $error("sel");
a_oe_release: assert property (ss_n[*8] |-> !miso_oe) else $error("oe");
a_out_quiet: assert property (!miso_oe |-> !miso_out) else $error("out");
sequence s_read_req;
	rd_strobe;
endsequence
sequence s_drive_on;
	##[2:8] miso_oe;
endsequence
a_rd_drive_on: assert property (s_read_req |-> s_drive_on) else $error("read drive");
a_strobe_excl: assert property (!(wr_strobe && rd_strobe)) else $error("both strobes");
endmodule
bind ssrp_port ssrp_mon mon_u(.clk(clk), .resetn(resetn), .ss_n(ss_n), .wr_strobe(wr_strobe),
	.rd_strobe(rd_strobe), .miso_oe(miso_oe), .miso_out(miso_out));
`default_nettype wire

// ==== tb/ssrp_master.sv ====
// Serial bus master model
`timescale 1ns/1ps
`default_nettype none
module ssrp_master(
	output logic sck,
	output logic ss_n,
	output logic mosi,
	input wire logic miso
);
initial begin
	sck = 0;
	ss_n = 1;
	mosi = 0;
end
task xfer(input logic [25:0] f, input int n, output logic [15:0] r);
	r = 16'h0000;
	ss_n = 0;
	#400;
	for (int i = 0; i < n; i++) begin
		mosi = f[25-i];
		#200 sck = 1;
		#200;
		if (i > 9) r = {r[14:0], miso};
		sck = 0;
	end
	#400 ss_n = 1;
	mosi = ~mosi;
	#800;
endtask
endmodule
`default_nettype wire

// ==== tb/ssrp_port_tb.sv ====
// Testbench for the serial port
`timescale 1ns/1ps
`default_nettype none
module ssrp_port_tb;
logic clk = 0, resetn = 0;
logic [15:0] rd_data = 16'h0000, r;
wire sck, ss_n, mosi, miso_out, miso_oe, wr_strobe, rd_strobe, miso;
wire [8:0] wr_addr, rd_addr;
wire [15:0] wr_data;
int miscompares = 0, comparisons = 0, wn = 0, rn = 0;
assign miso = miso_oe ? miso_out : 1'bz;
always #25 clk = ~clk;
always @(posedge clk) begin
	rd_data <= {7'h00, rd_addr} ^ 16'hA5C3;
	wn <= wn + wr_strobe;
	rn <= rn + rd_strobe;
end
ssrp_master m_u(.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
ssrp_port dut_u(.clk(clk), .resetn(resetn), .sck(sck), .ss_n(ss_n), .mosi(mosi),
	.miso_out(miso_out), .miso_oe(miso_oe), .wr_addr(wr_addr), .wr_data(wr_data),
	.wr_strobe(wr_strobe), .rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data));
task chk(input logic [25:0] g, input logic [25:0] e);
	comparisons++;
	if (g !== e) begin
		miscompares++;
		$display("[FAIL] %0t got %h exp %h", $time, g, e);
	end
endtask
task results;
	$display("comparisons %0d miscompares %0d", comparisons, miscompares);
	if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
task t_write;
	@(negedge clk);
	m_u.xfer({9'h1A5, 1'b1, 16'hC3E1}, 26, r);
	chk(wn, 1);
	chk({wr_addr, wr_data}, {9'h1A5, 16'hC3E1});
	chk(rn, 0);
	$display("write test done");
endtask
task t_read;
	@(negedge clk);
	m_u.xfer({9'h0F3, 1'b0, 16'h0000}, 26, r);
	chk(r, 16'hA530);
	chk(rd_addr, 9'h0F3);
	chk(rn, 1);
	chk(wn, 1);
	chk(miso, 1'bz);
	chk(miso_oe, 1'b0);
	$display("read test done");
endtask
task t_cut;
	@(negedge clk);
	m_u.xfer({9'h0AA, 1'b1, 16'hFFFF}, 20, r);
	chk(wn, 1);
	chk({wr_addr, wr_data}, {9'h1A5, 16'hC3E1});
	chk(rn, 1);
	$display("cut test done");
endtask
initial begin
	repeat (12) @(posedge clk);
	resetn <= 1;
	repeat (4) @(posedge clk);
	t_write;
	t_read;
	t_cut;
	results;
end
endmodule
`default_nettype wire
